// File: cwrs_reset_seq.sv
// How it works
// - Each reset source sets its own status flag; debug-forced reset sets none.
// - Entering reset requests self-clocked mode from the clock generator.
// - The reset pin is driven low for 34 bus cycles.
// - Pin released, sampled 38 cycles later to see whether it caused reset.
// - Enabled watchdog reaching timeout unserviced causes a system reset.
// - The options enable bit turns the watchdog on or off.
// - Any write to the status address restarts the watchdog.
// - A status address write leaves the status contents unchanged.
// - After every reset the watchdog comes up enabled.
// - Options register is write-once; only that write may disable watchdog.
// - Timeout select picks 2^18 or 2^13 bus cycles.
// - Active background debug suspends the watchdog.
`default_nettype none

module cwrs_reset_seq #(
  parameter int unsigned COP_LONG_CYCLES  = cwrs_pkg::COP_LONG_CYCLES,
  parameter int unsigned COP_SHORT_CYCLES = cwrs_pkg::COP_SHORT_CYCLES
) (
  // Clock and power-on reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Other reset sources and background debug status
  input  wire logic       lvdRstReq,
  input  wire logic       clkLossRstReq,
  input  wire logic       illegalOpRstReq,
  input  wire logic       bdmForceRstReq,
  input  wire logic       bdmActive,
  // Reset status register
  input  wire logic       srsWrStb,
  output logic [7:0]      srsRdData,
  // System options register
  input  wire logic       soptWrStb,
  input  wire logic [7:0] soptWrData,
  output logic [7:0]      soptRdData,
  // Reset pin, open drain
  input  wire logic       resetPinIn,
  output logic            resetPinOut,
  output logic            resetPinOeN,
  // System side
  output logic            sysRstOut,
  output logic            icgSelfClkReq,
  output logic            copEnable
);

  typedef struct packed {
    cwrs_pkg::cwrs_state_e          state;
    logic [cwrs_pkg::SEQ_CNT_W-1:0] cnt;
    logic [7:0]                     flags;
    logic                           copEn;
    logic                           copTsel;
    logic                           soptLocked;
    logic                           pinS1;
    logic                           pinS2;
  } cwrs_seq_s;

  localparam cwrs_seq_s RESET_ST = '{
    state:      cwrs_pkg::ST_DRIVE,
    cnt:        '0,
    flags:      cwrs_pkg::SRS_POR_RST,
    copEn:      cwrs_pkg::SYSTEM_OPTIONS_REGISTER_WATCHDOG_ENABLE_BIT_RST,
    copTsel:    cwrs_pkg::SYSTEM_OPTIONS_REGISTER_WATCHDOG_TIMEOUT_SELECT_RST,
    soptLocked: 1'h0,
    pinS1:      1'h1,
    pinS2:      1'h1
  };

  cwrs_seq_s  st_r;
  cwrs_seq_s  st_nxt;
  logic [7:0] srcNow;
  logic [7:0] srcSeq;
  logic       anySrc;
  logic       inRun;
  logic       copRun;
  logic       copClear;
  logic       copTimeout;

  function automatic logic [7:0] srcFlags(
    input logic lvd,
    input logic loss,
    input logic ilop,
    input logic cop,
    input logic pin
  );
    logic [7:0] f;
    f = '0;
    f[cwrs_pkg::SRS_LVD]  = lvd;
    f[cwrs_pkg::SRS_ICG]  = loss;
    f[cwrs_pkg::SRS_ILOP] = ilop;
    f[cwrs_pkg::SRS_COP]  = cop;
    f[cwrs_pkg::SRS_PIN]  = pin;
    return f;
  endfunction

  assign inRun = (st_r.state == cwrs_pkg::ST_RUN);
  // Suspended in debug, stopped while disabled or in reset
  assign copRun = st_r.copEn && inRun && !bdmActive;
  // Reset clears the timer so a new period starts on release
  assign copClear = srsWrStb || !inRun;

  cwrs_cop_timer #(
    .LONG_CYCLES  (COP_LONG_CYCLES),
    .SHORT_CYCLES (COP_SHORT_CYCLES)
  ) u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (copClear),
    .run      (copRun),
    .longSel  (st_r.copTsel),
    .timeout  (copTimeout)
  );

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pinS1 = resetPinIn;
    st_nxt.pinS2 = st_r.pinS1;
    srcNow = srcFlags(lvdRstReq, clkLossRstReq, illegalOpRstReq,
                      copTimeout, !st_r.pinS2);
    // Our own drive pulls the pin low, so it is not a source here
    srcSeq = srcFlags(lvdRstReq, clkLossRstReq, illegalOpRstReq,
                      1'b0, 1'b0);
    anySrc = (srcNow != '0) || bdmForceRstReq;
    case (st_r.state)
      cwrs_pkg::ST_RUN:
      begin
        // Service writes touch only the timer, never the flags
        if (soptWrStb && !st_r.soptLocked)
        begin
          st_nxt.copEn      = soptWrData[cwrs_pkg::SYSTEM_OPTIONS_REGISTER_WATCHDOG_ENABLE_BIT];
          st_nxt.copTsel    = soptWrData[cwrs_pkg::SYSTEM_OPTIONS_REGISTER_WATCHDOG_TIMEOUT_SELECT];
          st_nxt.soptLocked = 1'b1;
        end
        if (anySrc)
        begin
          st_nxt.state      = cwrs_pkg::ST_DRIVE;
          st_nxt.cnt        = '0;
          st_nxt.flags      = srcNow;
          st_nxt.copEn      = cwrs_pkg::SYSTEM_OPTIONS_REGISTER_WATCHDOG_ENABLE_BIT_RST;
          st_nxt.copTsel    = cwrs_pkg::SYSTEM_OPTIONS_REGISTER_WATCHDOG_TIMEOUT_SELECT_RST;
          st_nxt.soptLocked = 1'b0;
        end
      end
      cwrs_pkg::ST_DRIVE:
      begin
        st_nxt.flags = st_r.flags | srcSeq;
        if (st_r.cnt == cwrs_pkg::DRIVE_LAST)
        begin
          st_nxt.state = cwrs_pkg::ST_RELEASE;
          st_nxt.cnt   = '0;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      cwrs_pkg::ST_RELEASE:
      begin
        st_nxt.flags = st_r.flags | srcSeq;
        if (st_r.cnt == cwrs_pkg::SAMPLE_LAST)
        begin
          st_nxt.cnt = '0;
          if (!st_r.pinS2)
          begin
            st_nxt.flags[cwrs_pkg::SRS_PIN] = 1'b1;
            st_nxt.state = cwrs_pkg::ST_HOLD;
          end
          else
          begin
            st_nxt.state = cwrs_pkg::ST_RUN;
          end
        end
        else
        begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      cwrs_pkg::ST_HOLD:
      begin
        // External circuit still holds the pin; wait for it
        st_nxt.flags = st_r.flags | srcSeq;
        if (st_r.pinS2)
          st_nxt.state = cwrs_pkg::ST_RUN;
      end
      default:
      begin
        st_nxt.state = cwrs_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      st_r <= RESET_ST;
    else
      st_r <= st_nxt;
  end

  always_comb
  begin
    soptRdData = '0;
    soptRdData[cwrs_pkg::SYSTEM_OPTIONS_REGISTER_WATCHDOG_ENABLE_BIT] = st_r.copEn;
    soptRdData[cwrs_pkg::SYSTEM_OPTIONS_REGISTER_WATCHDOG_TIMEOUT_SELECT] = st_r.copTsel;
  end

  assign srsRdData     = st_r.flags;
  assign resetPinOut   = 1'b0;
  assign resetPinOeN   = (st_r.state != cwrs_pkg::ST_DRIVE);
  assign sysRstOut     = !inRun;
  assign icgSelfClkReq = !inRun;
  assign copEnable     = st_r.copEn;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  drive_length_a: assert property (
    $fell(resetPinOeN) |-> ##33 !resetPinOeN ##1 resetPinOeN)
    else $error("reset pin drive not 34 cycles");

  drive_early_a: assert property (
    $rose(resetPinOeN) |-> $past(!resetPinOeN, 34))
    else $error("reset pin released too early");

  sample_point_a: assert property (
    $rose(resetPinOeN) |-> ##37
      (st_r.state == cwrs_pkg::ST_RELEASE) ##1
      (st_r.state != cwrs_pkg::ST_RELEASE))
    else $error("pin not sampled 38 cycles after release");

  pin_flag_a: assert property (
    (st_r.state == cwrs_pkg::ST_RELEASE &&
     st_r.cnt == cwrs_pkg::SAMPLE_LAST && !st_r.pinS2)
    |=> srsRdData[cwrs_pkg::SRS_PIN] && sysRstOut)
    else $error("held pin not recorded");

  cop_reset_a: assert property (
    copTimeout |=> srsRdData[cwrs_pkg::SRS_COP] && !resetPinOeN)
    else $error("timeout did not start reset");

  lvd_flag_a: assert property (
    (inRun && lvdRstReq) |=>
      srsRdData[cwrs_pkg::SRS_LVD] && !srsRdData[cwrs_pkg::SRS_POR])
    else $error("low voltage source not recorded");

  bdm_noflag_a: assert property (
    (inRun && bdmForceRstReq && srcNow == '0) |=>
      (srsRdData == '0) && sysRstOut)
    else $error("debug reset set a flag");

  self_clock_a: assert property (
    $rose(sysRstOut) |-> icgSelfClkReq && !resetPinOeN)
    else $error("no self clock request on reset");

  enabled_after_a: assert property (
    $fell(sysRstOut) |-> copEnable &&
      soptRdData[cwrs_pkg::SYSTEM_OPTIONS_REGISTER_WATCHDOG_TIMEOUT_SELECT] == cwrs_pkg::SYSTEM_OPTIONS_REGISTER_WATCHDOG_TIMEOUT_SELECT_RST)
    else $error("watchdog not enabled after reset");

  write_once_a: assert property (
    (inRun && st_r.soptLocked && soptWrStb && !anySrc) |=>
      $stable(soptRdData))
    else $error("locked options register changed");

  first_write_a: assert property (
    (inRun && !st_r.soptLocked && soptWrStb && !anySrc) |=>
      copEnable == $past(soptWrData[cwrs_pkg::SYSTEM_OPTIONS_REGISTER_WATCHDOG_ENABLE_BIT]))
    else $error("first options write not taken");

  service_keep_a: assert property (
    (inRun && srsWrStb && !anySrc) |=> $stable(srsRdData))
    else $error("service write changed status");

  disabled_quiet_a: assert property (
    !copEnable |-> !copTimeout)
    else $error("timeout while disabled");

  debug_hold_a: assert property (
    bdmActive |-> !copTimeout)
    else $error("timeout in background mode");

  cop_reset_c: cover property (
    copTimeout ##1 sysRstOut [*8]);
  pin_hold_c: cover property (
    st_r.state == cwrs_pkg::ST_HOLD ##1 inRun);
  system_options_register_lock_c: cover property (
    inRun && !st_r.soptLocked && soptWrStb ##1 st_r.soptLocked);
  service_c: cover property (
    inRun && copRun && srsWrStb);

endmodule // cwrs_reset_seq

`default_nettype wire

// File: cwrs_pkg.sv
`default_nettype none

package cwrs_pkg;

  // Reset pin sequence, in bus cycles
  localparam int unsigned DRIVE_CYCLES  = 34;
  localparam int unsigned SAMPLE_CYCLES = 38;
  localparam int unsigned SEQ_CNT_W     = 6;
  localparam logic [SEQ_CNT_W-1:0] DRIVE_LAST =
    SEQ_CNT_W'(DRIVE_CYCLES - 1);
  localparam logic [SEQ_CNT_W-1:0] SAMPLE_LAST =
    SEQ_CNT_W'(SAMPLE_CYCLES - 1);

  // Watchdog periods, in bus cycles
  localparam int unsigned COP_CNT_W        = 18;
  localparam int unsigned COP_LONG_CYCLES  = 32'h0004_0000;
  localparam int unsigned COP_SHORT_CYCLES = 32'h0000_2000;

  // Reset status register bit positions
  localparam int unsigned SRS_POR  = 7;
  localparam int unsigned SRS_PIN  = 6;
  localparam int unsigned SRS_COP  = 5;
  localparam int unsigned SRS_ILOP = 4;
  localparam int unsigned SRS_ICG  = 2;
  localparam int unsigned SRS_LVD  = 1;
  localparam logic [7:0]  SRS_POR_RST = 8'h80;

  // System options register bit positions and reset values
  localparam int unsigned SYSTEM_OPTIONS_REGISTER_WATCHDOG_ENABLE_BIT     = 7;
  localparam int unsigned SYSTEM_OPTIONS_REGISTER_WATCHDOG_TIMEOUT_SELECT     = 6;
  localparam logic        SYSTEM_OPTIONS_REGISTER_WATCHDOG_ENABLE_BIT_RST = 1'h1;
  localparam logic        SYSTEM_OPTIONS_REGISTER_WATCHDOG_TIMEOUT_SELECT_RST = 1'h1;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_DRIVE,
    ST_RELEASE,
    ST_HOLD
  } cwrs_state_e;

endpackage

`default_nettype wire

// File: cwrs_cop_timer.sv
`default_nettype none

module cwrs_cop_timer #(
  parameter int unsigned LONG_CYCLES  = cwrs_pkg::COP_LONG_CYCLES,
  parameter int unsigned SHORT_CYCLES = cwrs_pkg::COP_SHORT_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Control
  input  wire logic clear,
  input  wire logic run,
  input  wire logic longSel,
  // Event
  output logic      timeout
);

  localparam int unsigned W = cwrs_pkg::COP_CNT_W;
  localparam logic [W-1:0] LONG_LAST  = W'(LONG_CYCLES - 1);
  localparam logic [W-1:0] SHORT_LAST = W'(SHORT_CYCLES - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
  } cwrs_tmr_s;

  cwrs_tmr_s  st_r;
  cwrs_tmr_s  st_nxt;
  logic       atLast;

  always_comb
  begin
    st_nxt = st_r;
    atLast = (st_r.cnt == (longSel ? LONG_LAST : SHORT_LAST));
    if (clear)
    begin
      st_nxt.cnt = '0;
    end
    else if (run)
    begin
      st_nxt.cnt = atLast ? '0 : st_r.cnt + 1'b1;
    end
    timeout = run && !clear && atLast;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  clear_zeroes_a: assert property (
    clear |=> (st_r.cnt == '0))
    else $error("watchdog count not restarted");
  // Count may still move on the edge where run drops, so look one later
  stopped_quiet_a: assert property (
    (!run && !clear) |-> !timeout ##1 $stable(st_r.cnt))
    else $error("watchdog moved while stopped");
  short_period_a: assert property (
    (run && !clear && !longSel && st_r.cnt == SHORT_LAST) |-> timeout)
    else $error("short period timeout missed");

endmodule // cwrs_cop_timer

`default_nettype wire

// File: cwrs_pin_model.sv
`default_nettype none

module cwrs_pin_model (
  // Device side of the pin
  input  wire logic resetPinOut,
  input  wire logic resetPinOeN,
  // Bench command: external circuit pulls low
  input  wire logic extHoldLow,
  // Resolved wire level
  output logic      pinLevel
);
  // Pull-up keeps a released pin high, never floating
  always_comb
  begin
    pinLevel = 1'b1;
    if (extHoldLow || (!resetPinOeN && !resetPinOut))
    begin
      pinLevel = 1'b0;
    end
  end
endmodule // cwrs_pin_model

`default_nettype wire

// File: cwrs_reset_seq_tb_top.sv
`default_nettype none

module cwrs_reset_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Shortened periods keep the run brief
  localparam int unsigned LONG  = 64;
  localparam int unsigned SHORT = 16;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] srcReq = 4'h0;
  logic       bdmActive = 1'b0;
  logic       srsWrStb = 1'b0;
  logic       soptWrStb = 1'b0;
  logic [7:0] soptWrData = 8'h00;
  logic       extHoldLow = 1'b0;
  logic       resetPinIn;
  logic       resetPinOut;
  logic       resetPinOeN;
  logic [7:0] srsRdData;
  logic [7:0] soptRdData;
  logic       sysRstOut;
  logic       icgSelfClkReq;
  logic       copEnable;
  int         mismatches = 0;
  int         checks_done = 0;
  logic [7:0] flagTab [4] = '{8'h00, 8'h02, 8'h04, 8'h10};

  always #50 core_clk = ~core_clk;

  cwrs_reset_seq #(.COP_LONG_CYCLES(LONG), .COP_SHORT_CYCLES(SHORT)) u_dut (
    .core_clk(core_clk), .rst(rst),
    .bdmForceRstReq(srcReq[0]), .lvdRstReq(srcReq[1]),
    .clkLossRstReq(srcReq[2]), .illegalOpRstReq(srcReq[3]),
    .bdmActive(bdmActive), .srsWrStb(srsWrStb), .srsRdData(srsRdData),
    .soptWrStb(soptWrStb), .soptWrData(soptWrData),
    .soptRdData(soptRdData), .resetPinIn(resetPinIn),
    .resetPinOut(resetPinOut), .resetPinOeN(resetPinOeN),
    .sysRstOut(sysRstOut), .icgSelfClkReq(icgSelfClkReq),
    .copEnable(copEnable)
  );

  cwrs_pin_model u_pin (
    .resetPinOut(resetPinOut), .resetPinOeN(resetPinOeN),
    .extHoldLow(extHoldLow), .pinLevel(resetPinIn)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Register write: one-cycle strobe launched off the falling edge
  task automatic wr(input bit toOpt, input logic [7:0] d);
    @(negedge core_clk);
    soptWrData = d;
    soptWrStb  = toOpt;
    srsWrStb   = !toOpt;
    @(negedge core_clk);
    soptWrStb = 1'b0;
    srsWrStb  = 1'b0;
  endtask

  task automatic waitRun();
    int n;
    n = 0;
    while (sysRstOut !== 1'b0 && n < 300)
    begin
      @(negedge core_clk);
      n++;
    end
    check(8'(sysRstOut), 8'h00);
  endtask

  // No reset may start during the span
  task automatic quiet(input int cyc);
    logic hit;
    hit = 1'b0;
    repeat (cyc)
    begin
      @(negedge core_clk);
      hit = hit | sysRstOut;
    end
    check(8'(hit), 8'h00);
  endtask

  // Wait for entry within lo..hi, then time the pin phases
  task automatic seq(input logic [7:0] flags, input int lo, input int hi);
    int n;
    n = 0;
    while (sysRstOut !== 1'b1 && n < hi)
    begin
      @(negedge core_clk);
      n++;
    end
    check(8'(n >= lo && sysRstOut === 1'b1), 8'h01);
    check(srsRdData, flags);
    n = 0;
    while (resetPinOeN === 1'b0 && n < 100)
    begin
      check(8'(icgSelfClkReq), 8'h01);
      @(negedge core_clk);
      n++;
    end
    check(8'(n), 8'd34);
    n = 0;
    while (sysRstOut === 1'b1 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    check(8'(n), 8'd38);
  endtask

  initial
  begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    waitRun();
    check(srsRdData, 8'h80);
    check(8'(resetPinOut), 8'h00);
    check({soptRdData[7:6], 5'h00, copEnable}, 8'hC1);
    wr(1'b1, 8'hC0);
    wr(1'b1, 8'h00);
    check(soptRdData, 8'hC0);
    check(8'(copEnable), 8'h01);
    seq(8'h20, LONG - 8, LONG + 4);
    wr(1'b1, 8'h80);
    wr(1'b1, 8'hC0);
    check(soptRdData, 8'h80);
    seq(8'h20, 4, SHORT + 4);
    check(soptRdData, 8'hC0);
    wr(1'b1, 8'h00);
    check(8'(copEnable), 8'h00);
    quiet(3 * LONG);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge core_clk);
      srcReq = 4'h1 << i;
      @(negedge core_clk);
      srcReq = 4'h0;
      seq(flagTab[i], 0, 4);
    end
    repeat (5)
    begin
      repeat (LONG - 20) @(negedge core_clk);
      wr(1'b0, 8'h5A);
    end
    check(8'(sysRstOut), 8'h00);
    check(srsRdData, 8'h10);
    bdmActive = 1'b1;
    wr(1'b0, 8'hFF);
    quiet(3 * LONG);
    bdmActive = 1'b0;
    seq(8'h20, LONG - 8, LONG + 4);
    extHoldLow = 1'b1;
    repeat (150) @(negedge core_clk);
    check(8'(sysRstOut), 8'h01);
    check(srsRdData, 8'h40);
    extHoldLow = 1'b0;
    waitRun();
    summarize();
  end

  // Whole run is near 1500 cycles
  initial
  begin
    #(100 * 8000);
    mismatches++;
    summarize();
  end
endmodule // cwrs_reset_seq_tb_top

`default_nettype wire
